// File: rtl/dpm_defines.svh
`ifndef DPM_DEFINES_SVH
`define DPM_DEFINES_SVH

`define DPM_ADDR_W 8
`define DPM_OFS_SER_LEVELS 8'h00
`define DPM_OFS_SER_LATCH 8'h04
`define DPM_OFS_SER_DIR 8'h08
`define DPM_OFS_BUS_LEVELS 8'h0c
`define DPM_OFS_BUS_LATCH 8'h10
`define DPM_OFS_BUS_DIR 8'h14
`define DPM_OFS_ODC_ONE 8'h18
`define DPM_OFS_ODC_THREE 8'h1c
`define DPM_OFS_PAD_CFG 8'h20
`define DPM_OFS_MEM_CTL 8'h24
`define DPM_OFS_OTHER_DIR 8'h28

`define DPM_RST_DIR 8'hff
`define DPM_RST_LATCH 8'h00
`define DPM_RST_ODC 8'h00
`define DPM_RST_PAD_CFG 8'h80
`define DPM_RST_MEM_CTL 8'h80
`define DPM_RST_OTHER_DIR 8'h00

`define DPM_PULLUP_DIS_BIT 7
`define DPM_EXT_BUS_DIS_BIT 7
`define DPM_PAR_SLAVE_BIT 4
`define DPM_SSP2_OD_BIT 0
`define DPM_SSP1_OD_BIT 7
`define DPM_XCV_OD_BIT 6

`define DPM_PIN_SER_CLK 3
`define DPM_PIN_SER_DIN 4
`define DPM_PIN_SER_DOUT 5
`define DPM_PIN_XCV_CLK 6
`define DPM_PIN_XCV_DAT 7
`define DPM_PIN_PULSE 0
`define DPM_PIN_TIMER 1
`define DPM_PIN_SPI2_DOUT 4
`define DPM_PIN_SPI2_CLK 6

`endif

// File: rtl/dpm_pad_cell.sv
module dpm_pad_cell (
	input wire logic drive,
	input wire logic value,
	input wire logic open_drain,
	output logic pad_out,
	output logic pad_oe
);
	// Open-drain only sinks; a high level is left to the pull-up
	assign pad_out = open_drain ? 1'b0 : value;
	assign pad_oe = drive & ~(open_drain & value);
endmodule

// File: rtl/dpm_pkg.sv
package dpm_pkg;
	typedef struct packed {
		logic spi_mode;
		logic i2c_mode;
		logic smbus_levels;
		logic spi_clock_out;
		logic spi_data_out;
		logic i2c_clock_low;
		logic i2c_data_low;
	} dpm_ssp_req_t;
	typedef struct packed {
		logic spi_clock_in;
		logic spi_data_in;
		logic i2c_clock_in;
		logic i2c_data_in;
	} dpm_ssp_rsp_t;
	typedef struct packed {
		logic enable;
		logic pin6_drive;
		logic pin6_value;
		logic pin7_drive;
		logic pin7_value;
	} dpm_xcv_req_t;
	typedef struct packed {
		logic receive;
		logic sync_clock;
		logic sync_data;
	} dpm_xcv_rsp_t;
	typedef struct packed {
		logic ext_drive;
		logic [7:0] ext_out;
		logic psp_drive;
		logic [7:0] psp_out;
		logic spi2_enable;
		logic spi2_clock_out;
		logic spi2_data_out;
		logic pulse_enable;
		logic pulse;
	} dpm_bus_req_t;
	typedef struct packed {
		logic [7:0] ext_in;
		logic [7:0] psp_in;
		logic ttl_levels;
		logic timer_clock;
		logic timer_gate;
	} dpm_bus_rsp_t;
	typedef struct packed {
		logic [7:0] ser_latch;
		logic [7:0] ser_dir;
		logic [7:0] bus_latch;
		logic [7:0] bus_dir;
		logic [7:0] odc_one;
		logic [7:0] odc_three;
		logic [7:0] pad_cfg;
		logic [7:0] mem_ctl;
		logic [7:0] other_dir;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] ser_out;
		logic [7:0] ser_oe;
		logic [7:0] bus_out;
		logic [7:0] bus_oe;
		logic [7:0] bus_pullup;
		logic [1:0] ser_i2c_levels;
		dpm_ssp_rsp_t ssp;
		dpm_xcv_rsp_t xcv;
		dpm_bus_rsp_t bus;
	} dpm_state_t;
endpackage

// File: rtl/dpm_port_mux.sv
// Summary of operation
// - Each bus-port pin has its own direction bit: drive latch, or sample pad.
// - Every reset brings all pins up as inputs with direction bits set.
// - Bus-port pins have weak pull-ups; pad config bit 7 disables them all.
// - A pin's pull-up is forced off while that pin drives.
// - Reset disables pull-ups by setting the shared pull-up disable bit.
// - On large package, port functions need external bus disable bit 7 set.
// - Enabled external bus owns the port as address/data low byte, ignoring direction.
// - Other-port direction bit 4 makes a parallel slave port with TTL inputs.
// - Second serial unit's SPI outputs go open-drain when control one bit 0 set.
// - Serial pin 3: SPI clock drives with direction 0, input with direction 1.
// - Serial pin 3: I2C clock overrides port data; input levels follow unit setting.
// - Serial pin 4: I2C data output overrides the latch while the unit drives.
// - Serial pin 4 feeds the SPI data input through the Schmitt path.
// - Serial pin 5 outputs SPI data when its direction bit is 0.
// - Serial pins 6, 7: transceiver output overrides latch while driving, direction 1.
// - Serial pin 6 supplies transceiver sync clock input when direction is 1.
// - Serial pin 7 feeds transceiver receive input when direction is 1.
// - Bus pin 1 feeds timer clock and gate; bus pin 0 carries the pulse output.
`include "dpm_defines.svh"
module dpm_port_mux (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`DPM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic large_package,
	input wire logic [7:0] ser_pad_in,
	output logic [7:0] ser_pad_out,
	output logic [7:0] ser_pad_oe,
	output logic [1:0] ser_pad_i2c_levels,
	input wire logic [7:0] bus_pad_in,
	output logic [7:0] bus_pad_out,
	output logic [7:0] bus_pad_oe,
	output logic [7:0] bus_pad_pullup,
	input wire dpm_pkg::dpm_ssp_req_t ssp_req,
	output dpm_pkg::dpm_ssp_rsp_t ssp_rsp,
	input wire dpm_pkg::dpm_xcv_req_t xcv_req,
	output dpm_pkg::dpm_xcv_rsp_t xcv_rsp,
	input wire dpm_pkg::dpm_bus_req_t bus_req,
	output dpm_pkg::dpm_bus_rsp_t bus_rsp
);
	import dpm_pkg::*;

	dpm_state_t st_q, st_d;
	logic [16:0] pad_sync;
	logic [7:0] ser_lvl;
	logic [7:0] bus_lvl;
	logic big_pkg;
	logic [15:0] cell_drive;
	logic [15:0] cell_value;
	logic [15:0] cell_od;
	logic [15:0] cell_out;
	logic [15:0] cell_oe;
	logic ext_bus_on;
	logic psp_on;
	logic setup_phase;
	logic write_now;
	logic addr_hit;
	logic [7:0] rd_byte;
	logic [7:0] wr_byte;

	// Pads and the package strap come from outside the clock domain
	dpm_sync #(
		.W(17)
	) u_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in({large_package, bus_pad_in, ser_pad_in}),
		.sync_out(pad_sync)
	);
	assign ser_lvl = pad_sync[7:0];
	assign bus_lvl = pad_sync[15:8];
	assign big_pkg = pad_sync[16];

	// Bus owns the pins unless disabled; small package has no bus at all
	assign ext_bus_on = big_pkg & ~st_q.mem_ctl[`DPM_EXT_BUS_DIS_BIT];
	assign psp_on = ~ext_bus_on & st_q.other_dir[`DPM_PAR_SLAVE_BIT];

	always_comb begin
		cell_drive = '0;
		cell_value = '0;
		cell_od = '0;
		// Plain port behaviour first, overrides below
		cell_drive[7:0] = ~st_q.ser_dir;
		cell_value[7:0] = st_q.ser_latch;
		if (ssp_req.spi_mode) begin
			if (!st_q.ser_dir[`DPM_PIN_SER_CLK]) begin
				cell_value[`DPM_PIN_SER_CLK] = ssp_req.spi_clock_out;
			end
			if (!st_q.ser_dir[`DPM_PIN_SER_DOUT]) begin
				cell_value[`DPM_PIN_SER_DOUT] = ssp_req.spi_data_out;
			end
			cell_od[`DPM_PIN_SER_CLK] = st_q.odc_one[`DPM_SSP1_OD_BIT];
			cell_od[`DPM_PIN_SER_DOUT] = st_q.odc_one[`DPM_SSP1_OD_BIT];
		end else if (ssp_req.i2c_mode) begin
			// Bus lines only ever pull low
			cell_drive[`DPM_PIN_SER_CLK] = ssp_req.i2c_clock_low;
			cell_value[`DPM_PIN_SER_CLK] = 1'b0;
			cell_drive[`DPM_PIN_SER_DIN] = ssp_req.i2c_data_low;
			cell_value[`DPM_PIN_SER_DIN] = 1'b0;
		end
		if (xcv_req.enable) begin
			// Direction stays as software left it; see sync data note
			if (st_q.ser_dir[`DPM_PIN_XCV_CLK]) begin
				cell_drive[`DPM_PIN_XCV_CLK] = xcv_req.pin6_drive;
				cell_value[`DPM_PIN_XCV_CLK] = xcv_req.pin6_value;
			end
			if (st_q.ser_dir[`DPM_PIN_XCV_DAT]) begin
				cell_drive[`DPM_PIN_XCV_DAT] = xcv_req.pin7_drive;
				cell_value[`DPM_PIN_XCV_DAT] = xcv_req.pin7_value;
			end
			cell_od[`DPM_PIN_XCV_CLK] = st_q.odc_three[`DPM_XCV_OD_BIT];
			cell_od[`DPM_PIN_XCV_DAT] = st_q.odc_three[`DPM_XCV_OD_BIT];
		end
		// Bus-shared port
		if (ext_bus_on) begin
			cell_drive[15:8] = {8{bus_req.ext_drive}};
			cell_value[15:8] = bus_req.ext_out;
		end else if (psp_on) begin
			cell_drive[15:8] = {8{bus_req.psp_drive}};
			cell_value[15:8] = bus_req.psp_out;
		end else begin
			cell_drive[15:8] = ~st_q.bus_dir;
			cell_value[15:8] = st_q.bus_latch;
			if (bus_req.pulse_enable) begin
				cell_drive[8 + `DPM_PIN_PULSE] = 1'b1;
				cell_value[8 + `DPM_PIN_PULSE] = bus_req.pulse;
			end
			if (bus_req.spi2_enable) begin
				if (!st_q.bus_dir[`DPM_PIN_SPI2_DOUT]) begin
					cell_value[8 + `DPM_PIN_SPI2_DOUT] = bus_req.spi2_data_out;
				end
				if (!st_q.bus_dir[`DPM_PIN_SPI2_CLK]) begin
					cell_value[8 + `DPM_PIN_SPI2_CLK] = bus_req.spi2_clock_out;
				end
				cell_od[8 + `DPM_PIN_SPI2_DOUT] = st_q.odc_one[`DPM_SSP2_OD_BIT];
				cell_od[8 + `DPM_PIN_SPI2_CLK] = st_q.odc_one[`DPM_SSP2_OD_BIT];
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_pad
			dpm_pad_cell u_cell (
				.drive(cell_drive[gi]),
				.value(cell_value[gi]),
				.open_drain(cell_od[gi]),
				.pad_out(cell_out[gi]),
				.pad_oe(cell_oe[gi])
			);
		end
	endgenerate

	// Register decode
	assign setup_phase = psel & ~penable;
	assign write_now = psel & penable & st_q.pready & pwrite & ~st_q.pslverr;
	assign wr_byte = pwdata[7:0];

	always_comb begin
		addr_hit = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			`DPM_OFS_SER_LEVELS: rd_byte = ser_lvl;
			`DPM_OFS_SER_LATCH: rd_byte = st_q.ser_latch;
			`DPM_OFS_SER_DIR: rd_byte = st_q.ser_dir;
			`DPM_OFS_BUS_LEVELS: rd_byte = bus_lvl;
			`DPM_OFS_BUS_LATCH: rd_byte = st_q.bus_latch;
			`DPM_OFS_BUS_DIR: rd_byte = st_q.bus_dir;
			`DPM_OFS_ODC_ONE: rd_byte = st_q.odc_one;
			`DPM_OFS_ODC_THREE: rd_byte = st_q.odc_three;
			`DPM_OFS_PAD_CFG: rd_byte = st_q.pad_cfg;
			`DPM_OFS_MEM_CTL: rd_byte = st_q.mem_ctl;
			`DPM_OFS_OTHER_DIR: rd_byte = st_q.other_dir;
			default: addr_hit = 1'b0;
		endcase
	end

	always_comb begin
		st_d = st_q;
		// Answer prepared in setup so pready can come from a flop
		st_d.pready = setup_phase;
		st_d.pslverr = setup_phase & ~addr_hit;
		st_d.prdata = (setup_phase & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
		if (write_now) begin
			case (paddr)
				`DPM_OFS_SER_LEVELS: st_d.ser_latch = wr_byte;
				`DPM_OFS_SER_LATCH: st_d.ser_latch = wr_byte;
				`DPM_OFS_SER_DIR: st_d.ser_dir = wr_byte;
				`DPM_OFS_BUS_LEVELS: st_d.bus_latch = wr_byte;
				`DPM_OFS_BUS_LATCH: st_d.bus_latch = wr_byte;
				`DPM_OFS_BUS_DIR: st_d.bus_dir = wr_byte;
				`DPM_OFS_ODC_ONE: st_d.odc_one = wr_byte;
				`DPM_OFS_ODC_THREE: st_d.odc_three = wr_byte;
				`DPM_OFS_PAD_CFG: st_d.pad_cfg = wr_byte;
				`DPM_OFS_MEM_CTL: st_d.mem_ctl = wr_byte;
				`DPM_OFS_OTHER_DIR: st_d.other_dir = wr_byte;
				default: st_d.pslverr = st_q.pslverr;
			endcase
		end
		// Pads driven one cycle after the control change
		st_d.ser_out = cell_out[7:0];
		st_d.ser_oe = cell_oe[7:0];
		st_d.bus_out = cell_out[15:8];
		st_d.bus_oe = cell_oe[15:8];
		// Pull-up shares one disable, but never fights a driven pin
		st_d.bus_pullup = ~cell_oe[15:8] & {8{~st_q.pad_cfg[`DPM_PULLUP_DIS_BIT]}};
		st_d.ser_i2c_levels = {2{ssp_req.i2c_mode & ssp_req.smbus_levels}};
		// Peripheral inputs
		st_d.ssp.spi_clock_in = ser_lvl[`DPM_PIN_SER_CLK];
		st_d.ssp.spi_data_in = ser_lvl[`DPM_PIN_SER_DIN];
		st_d.ssp.i2c_clock_in = ser_lvl[`DPM_PIN_SER_CLK];
		st_d.ssp.i2c_data_in = ser_lvl[`DPM_PIN_SER_DIN];
		// Idle-high when the pin is not an input, so no false start bits
		st_d.xcv.sync_clock = st_q.ser_dir[`DPM_PIN_XCV_CLK] ? ser_lvl[`DPM_PIN_XCV_CLK] : 1'b1;
		st_d.xcv.receive = st_q.ser_dir[`DPM_PIN_XCV_DAT] ? ser_lvl[`DPM_PIN_XCV_DAT] : 1'b1;
		st_d.xcv.sync_data = st_q.ser_dir[`DPM_PIN_XCV_DAT] ? ser_lvl[`DPM_PIN_XCV_DAT] : 1'b1;
		st_d.bus.ext_in = bus_lvl;
		st_d.bus.psp_in = bus_lvl;
		st_d.bus.ttl_levels = ext_bus_on | psp_on;
		st_d.bus.timer_clock = bus_lvl[`DPM_PIN_TIMER];
		st_d.bus.timer_gate = bus_lvl[`DPM_PIN_TIMER];
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
			st_q.ser_latch <= `DPM_RST_LATCH;
			st_q.ser_dir <= `DPM_RST_DIR;
			st_q.bus_latch <= `DPM_RST_LATCH;
			st_q.bus_dir <= `DPM_RST_DIR;
			st_q.odc_one <= `DPM_RST_ODC;
			st_q.odc_three <= `DPM_RST_ODC;
			st_q.pad_cfg <= `DPM_RST_PAD_CFG;
			st_q.mem_ctl <= `DPM_RST_MEM_CTL;
			st_q.other_dir <= `DPM_RST_OTHER_DIR;
			st_q.xcv <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign ser_pad_out = st_q.ser_out;
	assign ser_pad_oe = st_q.ser_oe;
	assign ser_pad_i2c_levels = st_q.ser_i2c_levels;
	assign bus_pad_out = st_q.bus_out;
	assign bus_pad_oe = st_q.bus_oe;
	assign bus_pad_pullup = st_q.bus_pullup;
	assign ssp_rsp = st_q.ssp;
	assign xcv_rsp = st_q.xcv;
	assign bus_rsp = st_q.bus;
endmodule

// File: rtl/dpm_sync.sv
module dpm_sync #(
	parameter int W = 17
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} dpm_sync_st_t;
	dpm_sync_st_t st_q, st_d;
	always_comb begin
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign sync_out = st_q.stable;
endmodule

// File: testbench/dpm_pad_model.sv
module dpm_pad_model (
	input wire logic sys_clk,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pull_hi,
	input wire logic [7:0] ext_oe,
	input wire logic [7:0] ext_val,
	output logic [7:0] level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] float_q = 8'h5a;
	// Undriven lines wander so nothing matches by luck
	always @(posedge sys_clk)
		float_q <= ~float_q;
	always_comb
		for (int i = 0; i < 8; i++)
			level[i] = pad_oe[i] ? pad_out[i] : ext_oe[i] ? ext_val[i] : pull_hi[i] | float_q[i];
endmodule

// File: testbench/dpm_port_mux_monitor.sv
module dpm_port_mux_monitor (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [7:0] ser_pad_in,
	input wire logic [7:0] ser_pad_out,
	input wire logic [7:0] ser_pad_oe,
	input wire logic [1:0] ser_pad_i2c_levels,
	input wire logic [7:0] bus_pad_in,
	input wire logic [7:0] bus_pad_oe,
	input wire logic [7:0] bus_pad_pullup,
	input wire dpm_pkg::dpm_ssp_req_t ssp_req,
	input wire dpm_pkg::dpm_ssp_rsp_t ssp_rsp,
	input wire dpm_pkg::dpm_bus_rsp_t bus_rsp
);
	import dpm_pkg::*;
	logic [1:0] up_q;
	// Synchronisers and response flops show reset values for three edges
	always_ff @(posedge sys_clk or negedge arst_n)
		if (!arst_n)
			up_q <= 2'h0;
		else if (up_q != 2'h3)
			up_q <= up_q + 2'h1;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	chk_reset_inputs: assert property (
		$rose(arst_n) |-> (ser_pad_oe == 8'h0 && bus_pad_oe == 8'h0 && bus_pad_pullup == 8'h0) [*2])
		else $error("pins not inputs after reset");
	chk_pullup_off_out: assert property (
		(bus_pad_pullup & bus_pad_oe) == 8'h0) else $error("pull-up on a driven pin");
	chk_i2c_levels: assert property (
		ssp_req.i2c_mode && ssp_req.smbus_levels |=> ser_pad_i2c_levels == 2'h3) else $error("i2c levels");
	chk_i2c_clock: assert property (
		ssp_req.i2c_mode && !ssp_req.spi_mode |=> ser_pad_oe[3] == $past(ssp_req.i2c_clock_low) && !ser_pad_out[3])
		else $error("i2c clock pin");
	chk_i2c_data: assert property (
		ssp_req.i2c_mode && !ssp_req.spi_mode |=> ser_pad_oe[4] == $past(ssp_req.i2c_data_low) && !ser_pad_out[4])
		else $error("i2c data pin");
	chk_sdi_path: assert property (
		up_q == 2'h3 |-> ssp_rsp.spi_data_in == $past(ser_pad_in[4], 3)) else $error("spi data input");
	chk_sck_input: assert property (
		up_q == 2'h3 |-> {ssp_rsp.spi_clock_in, ssp_rsp.i2c_clock_in} == {2{$past(ser_pad_in[3], 3)}})
		else $error("serial clock input");
	chk_timer_inputs: assert property (
		up_q == 2'h3 |-> {bus_rsp.timer_clock, bus_rsp.timer_gate} == {2{$past(bus_pad_in[1], 3)}})
		else $error("timer inputs");
	chk_bus_inputs: assert property (
		up_q == 2'h3 |-> {bus_rsp.ext_in, bus_rsp.psp_in} == {2{$past(bus_pad_in, 3)}})
		else $error("bus port inputs");
	chk_sda_input: assert property (
		up_q == 2'h3 |-> ssp_rsp.i2c_data_in == $past(ser_pad_in[4], 3)) else $error("i2c data input");
endmodule
bind dpm_port_mux dpm_port_mux_monitor mon (.*);

// File: testbench/dpm_port_mux_test.sv
module dpm_port_mux_test;
	timeunit 1ns;
	timeprecision 1ns;
	import dpm_pkg::*;
	typedef struct packed {logic k; logic [63:0] m; logic [63:0] v;} dpm_note_t;
	localparam int SOE = 56, SDO = 48, BOE = 40, BDO = 32, BPU = 24;
	localparam logic [15:0] RST [9] = '{16'h0400, 16'h08ff, 16'h1000, 16'h14ff, 16'h1800, 16'h1c00, 16'h2080,
		16'h2480, 16'h2800};
	dpm_note_t notes_q[$];
	logic sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, large_package = 1'b0;
	logic look = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h0, s_eo = 8'h0, s_ev = 8'h0, b_eo = 8'h0, b_ev = 8'h0;
	logic [7:0] ser_pad_in, ser_pad_out, ser_pad_oe, bus_pad_in, bus_pad_out, bus_pad_oe, bus_pad_pullup;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [1:0] ser_pad_i2c_levels;
	dpm_ssp_req_t ssp_req = '0;
	dpm_ssp_rsp_t ssp_rsp;
	dpm_xcv_req_t xcv_req = '0;
	dpm_xcv_rsp_t xcv_rsp;
	dpm_bus_req_t bus_req = '0;
	dpm_bus_rsp_t bus_rsp;
	int err_count = 0, n_tests = 0;
	wire [63:0] obs = {ser_pad_oe, ser_pad_out, bus_pad_oe, bus_pad_out, bus_pad_pullup, ssp_rsp, xcv_rsp,
		bus_rsp.ttl_levels, bus_rsp.timer_clock, bus_rsp.timer_gate, ser_pad_i2c_levels, 12'h0};
	dpm_port_mux dut (.*);
	dpm_pad_model ser_far (.sys_clk, .pad_out(ser_pad_out), .pad_oe(ser_pad_oe), .pull_hi(8'h0), .ext_oe(s_eo),
		.ext_val(s_ev), .level(ser_pad_in));
	dpm_pad_model bus_far (.sys_clk, .pad_out(bus_pad_out), .pad_oe(bus_pad_oe), .pull_hi(bus_pad_pullup),
		.ext_oe(b_eo), .ext_val(b_ev), .level(bus_pad_in));
	always #20 sys_clk = ~sys_clk;
	function automatic logic [63:0] at(input int p, input logic [7:0] x);
		return {56'h0, x} << p;
	endfunction
	task automatic bad(input string s);
		$display("MISMATCH %0t %s", $time, s);
		err_count++;
	endtask
	task automatic close_out;
		if (err_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp_rd(input dpm_note_t e);
		n_tests++;
		if (({31'h0, pslverr, prdata} & e.m) !== e.v)
			bad("read data");
	endtask
	task automatic cmp_pad(input dpm_note_t e);
		n_tests++;
		if ((obs & e.m) !== e.v)
			bad("pad state");
	endtask
	always @(posedge sys_clk)
		if (psel && penable && pready === 1'b1)
			cmp_rd(notes_q.pop_front());
		else if (look)
			cmp_pad(notes_q.pop_front());
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [32:0] x);
		int n;
		notes_q.push_back({1'b0, w ? 64'h1_0000_0000 : 64'h1_ffff_ffff, {31'h0, x}});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 9; n++) begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		if (n == 9) begin
			bad("no ready");
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d);
		apb(1'b0, a, 8'h0, {25'h0, d});
	endtask
	// Pads and responses settle within four edges of any change
	task automatic pads(input logic [63:0] m, input logic [63:0] v);
		repeat (5) @(posedge sys_clk);
		notes_q.push_back({1'b1, m, v & m});
		look <= 1'b1;
		@(posedge sys_clk);
		look <= 1'b0;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad("timeout");
		close_out();
	end
	initial begin
		logic [7:0] r, v, e;
		void'($urandom(32'hf7b73667));
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 9; i++)
			rd(RST[i][15:8], RST[i][7:0]);
		apb(1'b0, 8'h2c, 8'h0, 33'h1_0000_0000);
		apb(1'b1, 8'h2c, 8'h5a, 33'h1_0000_0000);
		pads(at(SOE, 8'hff) | at(BOE, 8'hff) | at(BPU, 8'hff), 64'h0);
		r = 8'($urandom);
		v = 8'($urandom);
		e = 8'($urandom);
		b_eo <= r;
		b_ev <= e;
		wr(8'h14, r);
		wr(8'h10, v);
		wr(8'h20, 8'h00);
		pads(at(BOE, 8'hff) | at(BDO, ~r) | at(BPU, 8'hff), at(BOE, ~r) | at(BDO, v) | at(BPU, r));
		rd(8'h0c, (v & ~r) | (e & r));
		wr(8'h0c, ~v);
		rd(8'h10, ~v);
		wr(8'h20, 8'h80);
		pads(at(BPU, 8'hff), 64'h0);
		large_package <= 1'b1;
		bus_req.ext_drive <= 1'b1;
		bus_req.ext_out <= v;
		pads(at(BOE, 8'hff), at(BOE, ~r));
		wr(8'h24, 8'h00);
		pads(at(BOE, 8'hff) | at(BDO, 8'hff), at(BOE, 8'hff) | at(BDO, v));
		bus_req.ext_drive <= 1'b0;
		pads(at(BOE, 8'hff), 64'h0);
		large_package <= 1'b0;
		pads(at(BOE, 8'hff), at(BOE, ~r));
		wr(8'h28, 8'h10);
		bus_req.psp_drive <= 1'b1;
		bus_req.psp_out <= e;
		pads(at(BOE, 8'hff) | at(BDO, 8'hff) | 64'h1_0000, at(BOE, 8'hff) | at(BDO, e) | 64'h1_0000);
		bus_req.psp_drive <= 1'b0;
		wr(8'h28, 8'h00);
		pads(64'h1_0000, 64'h0);
		wr(8'h14, 8'hef);
		wr(8'h18, 8'h01);
		b_eo <= 8'h02;
		b_ev <= 8'h02;
		bus_req <= '{pulse_enable: 1'b1, pulse: 1'b1, spi2_enable: 1'b1, default: '0};
		pads(at(BOE, 8'h13) | at(BDO, 8'h11) | 64'hc000, at(BOE, 8'h11) | at(BDO, 8'h01) | 64'hc000);
		bus_req <= '{pulse_enable: 1'b1, spi2_enable: 1'b1, spi2_data_out: 1'b1, default: '0};
		b_ev <= 8'h00;
		pads(at(BOE, 8'h13) | at(BDO, 8'h01) | 64'hc000, at(BOE, 8'h01));
		bus_req <= '0;
		wr(8'h08, 8'hd7);
		s_eo <= 8'h10;
		for (int i = 0; i < 2; i++) begin
			ssp_req <= '{spi_mode: 1'b1, spi_clock_out: i[0], spi_data_out: ~i[0], default: '0};
			s_ev <= {3'h0, i[0], 4'h0};
			pads(at(SOE, 8'h28) | at(SDO, 8'h28) | 64'h40_0000, at(SOE, 8'h28)
				| at(SDO, {2'h0, ~i[0], 1'b0, i[0], 3'h0}) | ({63'h0, i[0]} << 22));
		end
		// First serial unit open-drain: high clock released, low data still sinks
		wr(8'h18, 8'h80);
		pads(at(SOE, 8'h28) | at(SDO, 8'h28), at(SOE, 8'h20));
		ssp_req <= '{i2c_mode: 1'b1, smbus_levels: 1'b1, i2c_clock_low: 1'b1, default: '0};
		pads(at(SOE, 8'h18) | at(SDO, 8'h08) | 64'h3000, at(SOE, 8'h08) | 64'h3000);
		ssp_req <= '{i2c_mode: 1'b1, i2c_data_low: 1'b1, default: '0};
		pads(at(SOE, 8'h18) | at(SDO, 8'h10) | 64'h3000, at(SOE, 8'h10));
		ssp_req <= '0;
		wr(8'h08, 8'hc0);
		s_eo <= 8'h80;
		for (int i = 0; i < 2; i++) begin
			xcv_req <= '{enable: 1'b1, pin6_drive: 1'b1, pin6_value: i[0], default: '0};
			s_ev <= {i[0], 7'h0};
			pads(at(SOE, 8'hc0) | at(SDO, 8'h40) | 64'he_0000, at(SOE, 8'h40)
				| at(SDO, {1'b0, i[0], 6'h0}) | ({61'h0, {3{i[0]}}} << 17));
		end
		rd(8'h00, 8'hc0);
		wr(8'h00, 8'h25);
		rd(8'h04, 8'h25);
		s_ev <= 8'h00;
		wr(8'h08, 8'h3f);
		pads(at(SOE, 8'hc0) | 64'h8_0000, at(SOE, 8'hc0) | 64'h8_0000);
		// Second reset in mid-run; transceiver quiet so its drive does not mask the check
		xcv_req <= '0;
		s_eo <= 8'h00;
		arst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 9; i++)
			rd(RST[i][15:8], RST[i][7:0]);
		pads(at(SOE, 8'hff) | at(BOE, 8'hff) | at(BPU, 8'hff), 64'h0);
		close_out();
	end
endmodule
